// [rtl/cog_pkg.sv]
package cog_pkg;

  // output count and enable defaults
  localparam int          COG_NUM_OUT      = 9;
  localparam logic [8:0]  COG_GATE_BIT_RST = 9'h1FF;

  // restart latency window, in output clock cycles
  localparam int          COG_LAT_MIN_CYC  = 2;
  localparam int          COG_LAT_MAX_CYC  = 6;

  // clock stabilisation bound after power-up
  localparam real         COG_STABLE_MS    = 1.8;
  localparam real         COG_CLK_MHZ      = 250.0;
  localparam int          COG_STABLE_CYC   = int'(COG_STABLE_MS * COG_CLK_MHZ * 1000.0);

  // power-good / power-down pin states
  typedef enum logic [1:0]
  {
    COG_WAIT_GOOD,
    COG_RUN,
    COG_POWER_DOWN
  } cog_pwr_e;

endpackage : cog_pkg

// [rtl/cog_gate.sv]
`timescale 1ns/1ps
// one output gate: enable synchronised to mclk, gate updated only in low phase
module cog_gate
  import cog_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // control
  input  wire logic enable,
  input  wire logic phase_hi,
  // gate state
  output logic      gate_on
);

  logic sync1_q;
  logic sync1_d;
  logic sync2_q;
  logic sync2_d;
  logic gate_q;
  logic gate_d;

  // two-stage synchroniser, gate follows only while output clock is low
  always_comb
  begin
    sync1_d = enable;
    sync2_d = sync1_q;
    gate_d  = gate_q;
    if (!phase_hi)
    begin
      gate_d = sync2_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      gate_q  <= 1'b0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      gate_q  <= gate_d;
    end
  end

  assign gate_on = gate_q;

endmodule : cog_gate

// [rtl/cog_top.sv]
`timescale 1ns/1ps
// Overview of operation
// - before power-good, outputs off, logic alive
// - after power-good high, pin means power-down
// - power-down low disables outputs and logic
// - power-down stops outputs low, glitch-free
// - power-down release restarts within 2-6 cycles
// - output runs when pin and bit high
// - gate bits reset to enabled
// - gating stops only affected output
// - resumed pulses always full width
// - start output within 2-6 cycles
// - stop after full cycle, hold low
// - stable clocks within 1.8 ms
// - per-output bit, 0 off, 1 on
module cog_top
  import cog_pkg::*;
(
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // system pins
  input  wire logic                   power_good_or_down_pin,
  input  wire logic [COG_NUM_OUT-1:0] out_enable_pin,
  // serial-bus gate bit writes
  input  wire logic                   gate_bits_we,
  input  wire logic [COG_NUM_OUT-1:0] gate_bits_wdata,
  // clock outputs and status
  output logic      [COG_NUM_OUT-1:0] clock_out_a,
  output logic      [COG_NUM_OUT-1:0] gate_bits,
  output logic                        power_down_n,
  output logic                        logic_alive,
  output logic                        clocks_stable
);

  cog_pwr_e               pwr_q;
  cog_pwr_e               pwr_d;
  logic                   pin_s1_q;
  logic                   pin_s2_q;
  logic [COG_NUM_OUT-1:0] bits_q;
  logic [COG_NUM_OUT-1:0] bits_d;
  logic                   phase_q;
  logic                   phase_d;
  logic [COG_NUM_OUT-1:0] gate_on;
  logic [COG_NUM_OUT-1:0] out_q;
  logic [COG_NUM_OUT-1:0] out_d;
  logic [COG_NUM_OUT-1:0] en_q;
  logic [COG_NUM_OUT-1:0] en_d;
  logic [COG_NUM_OUT-1:0] ena_pin_s1_q;
  logic [COG_NUM_OUT-1:0] ena_pin_s2_q;
  logic                   alive_q;
  logic                   alive_d;
  logic                   run_q;
  logic                   run_d;
  logic [20:0]            stab_cnt_q;
  logic [20:0]            stab_cnt_d;
  logic                   stable_q;
  logic                   stable_d;

  // pin synchronisers, pins come from outside the clock domain
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_s1_q     <= 1'b0;
      pin_s2_q     <= 1'b0;
      ena_pin_s1_q <= '0;
      ena_pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q     <= power_good_or_down_pin;
      pin_s2_q     <= pin_s1_q;
      ena_pin_s1_q <= out_enable_pin;
      ena_pin_s2_q <= ena_pin_s1_q;
    end
  end

  // dual-function pin state machine
  always_comb
  begin
    pwr_d = pwr_q;
    case (pwr_q)
      COG_WAIT_GOOD:
      begin
        if (pin_s2_q)
        begin
          pwr_d = COG_RUN;
        end
      end
      COG_RUN:
      begin
        if (!pin_s2_q)
        begin
          pwr_d = COG_POWER_DOWN;
        end
      end
      COG_POWER_DOWN:
      begin
        if (pin_s2_q)
        begin
          pwr_d = COG_RUN;
        end
      end
      default:
      begin
        pwr_d = COG_WAIT_GOOD;
      end
    endcase
  end

  // serial-bus gate bits, logic is dead in power-down
  always_comb
  begin
    bits_d = bits_q;
    if (gate_bits_we && (pwr_q != COG_POWER_DOWN))
    begin
      bits_d = gate_bits_wdata;
    end
  end

  // output clock is mclk divided by two
  always_comb
  begin
    phase_d = ~phase_q;
    alive_d = (pwr_d != COG_POWER_DOWN);
    run_d   = (pwr_q == COG_RUN);
    en_d    = ena_pin_s2_q & bits_q & {COG_NUM_OUT{run_q}};
  end

  // per-output gates, each independent
  // only affected output stops
  for (genvar i = 0; i < COG_NUM_OUT; i++)
  begin : g_gate
    cog_gate cog_gate_i
    (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .enable   (en_q[i]),
      .phase_hi (phase_q),
      .gate_on  (gate_on[i])
    );
  end

  // output drive: gate only changes in low phase
  always_comb
  begin
    out_d = gate_on & {COG_NUM_OUT{~phase_q}};
  end

  // stabilisation counter after power-up
  always_comb
  begin
    stab_cnt_d = stab_cnt_q;
    stable_d   = stable_q;
    if (stab_cnt_q == 21'(COG_STABLE_CYC - 1))
    begin
      stable_d = 1'b1;
    end
    else
    begin
      stab_cnt_d = stab_cnt_q + 21'h000001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pwr_q      <= COG_WAIT_GOOD;
      bits_q     <= COG_GATE_BIT_RST;
      phase_q    <= 1'b0;
      en_q       <= '0;
      out_q      <= '0;
      alive_q    <= 1'b1;
      run_q      <= 1'b0;
      stab_cnt_q <= '0;
      stable_q   <= 1'b0;
    end
    else
    begin
      pwr_q      <= pwr_d;
      bits_q     <= bits_d;
      phase_q    <= phase_d;
      en_q       <= en_d;
      out_q      <= out_d;
      alive_q    <= alive_d;
      run_q      <= run_d;
      stab_cnt_q <= stab_cnt_d;
      stable_q   <= stable_d;
    end
  end

  assign clock_out_a   = out_q;
  assign gate_bits     = bits_q;
  assign power_down_n  = run_q;
  assign logic_alive   = alive_q;
  assign clocks_stable = stable_q;

  // outputs low once not running for seven cycles
  property p_pd_low;
    @(posedge mclk) disable iff (!rst_n)
      (!run_q) [*7] |-> (out_q == '0);
  endproperty
  a_pd_low: assert property (p_pd_low) else $error("output active while off");

  // power-down stops the logic
  property p_pd_logic;
    @(posedge mclk) disable iff (!rst_n)
      (pwr_q == COG_POWER_DOWN) |-> !alive_q;
  endproperty
  a_pd_logic: assert property (p_pd_logic) else $error("logic alive in power-down");

  // before power-good logic stays alive
  property p_wait_alive;
    @(posedge mclk) disable iff (!rst_n)
      (pwr_q == COG_WAIT_GOOD) |-> (alive_q && out_q == '0);
  endproperty
  a_wait_alive: assert property (p_wait_alive) else $error("bad pre-good state");

  // first high qualifies the pin
  property p_qualify;
    @(posedge mclk) disable iff (!rst_n)
      (pwr_q == COG_WAIT_GOOD && pin_s2_q) |=> (pwr_q == COG_RUN);
  endproperty
  a_qualify: assert property (p_qualify) else $error("pin not qualified");

  // low after qualification powers down
  property p_enter_pd;
    @(posedge mclk) disable iff (!rst_n)
      (pwr_q == COG_RUN && !pin_s2_q) |=> (pwr_q == COG_POWER_DOWN);
  endproperty
  a_enter_pd: assert property (p_enter_pd) else $error("no power-down");

  // enabled output pulses within six output cycles
  property p_start;
    @(posedge mclk) disable iff (!rst_n)
      $rose(en_q[0]) ##1 en_q[0] [*8] |-> ##[0:4] out_q[0];
  endproperty
  a_start: assert property (p_start) else $error("output start late");

  // either enable low keeps output off
  property p_gate_and;
    @(posedge mclk) disable iff (!rst_n)
      (!en_q[0]) [*6] |-> !out_q[0];
  endproperty
  a_gate_and: assert property (p_gate_and) else $error("output runs while disabled");

  // every high pulse on output 0 is exactly one cycle then low
  property p_full_pulse;
    @(posedge mclk) disable iff (!rst_n)
      $rose(out_q[0]) |=> !out_q[0];
  endproperty
  a_full_pulse: assert property (p_full_pulse) else $error("stretched pulse");

  // gate bits reset to enabled
  property p_bits_rst;
    @(posedge mclk) $rose(rst_n) |-> (bits_q == COG_GATE_BIT_RST);
  endproperty
  a_bits_rst: assert property (p_bits_rst) else $error("gate bits not default");

endmodule : cog_top

// [dv/cog_sys_model.sv]
`timescale 1ns/1ps
// system side: drives the power pin and the enable pins
module cog_sys_model
  import cog_pkg::*;
(
  // clock
  input  wire logic                   mclk,
  // driven pins
  output logic                        pin,
  output logic      [COG_NUM_OUT-1:0] en_pin
);
  // defined levels
  // pins hold a defined level from time zero and never float
  initial
  begin
    pin    = 1'h0;
    en_pin = 9'h1FF;
  end

  // level changes
  // new levels land just after a rising edge
  task automatic drive(input logic p, input logic [COG_NUM_OUT-1:0] e);
    @(posedge mclk);
    pin    <= p;
    en_pin <= e;
  endtask : drive
endmodule : cog_sys_model

// [dv/clock_output_gating_tb_top.sv]
`timescale 1ns/1ps
// bench for the output gating block
module clock_output_gating_tb_top
  import cog_pkg::*;
;
  logic                   mclk;
  logic                   rst_n;
  logic                   pin;
  logic [COG_NUM_OUT-1:0] en_pin;
  logic                   gate_bits_we;
  logic [COG_NUM_OUT-1:0] gate_bits_wdata;
  logic [COG_NUM_OUT-1:0] clock_out_a;
  logic [COG_NUM_OUT-1:0] gate_bits;
  logic                   power_down_n;
  logic                   logic_alive;
  logic                   clocks_stable;
  int                     n_fail;
  int                     checks;

  // design and system model
  cog_top cog_top_i (
    .mclk(mclk), .rst_n(rst_n), .power_good_or_down_pin(pin), .out_enable_pin(en_pin),
    .gate_bits_we(gate_bits_we), .gate_bits_wdata(gate_bits_wdata),
    .clock_out_a(clock_out_a), .gate_bits(gate_bits), .power_down_n(power_down_n),
    .logic_alive(logic_alive), .clocks_stable(clocks_stable)
  );
  cog_sys_model cog_sys_model_i (.mclk(mclk), .pin(pin), .en_pin(en_pin));

  // clock generation
  initial
  begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // compare and count
  task automatic check(input string what, input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // one-cycle gate bit write strobe
  task automatic wr_bits(input logic [8:0] v);
    @(posedge mclk);
    gate_bits_we    <= 1'h1;
    gate_bits_wdata <= v;
    @(posedge mclk);
    gate_bits_we    <= 1'h0;
    @(negedge mclk);
  endtask : wr_bits

  // edges from request to first high output, bounded
  task automatic start_lat(input int i);
    int n;
    n = 0;
    while (clock_out_a[i] !== 1'h1 && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    check("start_latency", 9'(n >= 2 * COG_LAT_MIN_CYC && n <= 2 * COG_LAT_MAX_CYC), 9'h001);
  endtask : start_lat

  // running output toggles every cycle: one high, one low
  task automatic full_pulses(input int i);
    logic prev;
    prev = clock_out_a[i];
    repeat (8)
    begin
      @(negedge mclk);
      check("pulse", 9'(clock_out_a[i] != prev), 9'h001);
      prev = clock_out_a[i];
    end
  endtask : full_pulses

  // stopping output: no stretched high, then held low
  task automatic stops_low(input int i);
    logic prev;
    prev = 1'h0;
    for (int k = 0; k < 24; k++)
    begin
      @(negedge mclk);
      if (clock_out_a[i] === 1'h1)
        check("no_stretch", 9'(prev), 9'h000);
      if (k >= 16)
        check("held_low", 9'(clock_out_a[i]), 9'h000);
      prev = clock_out_a[i];
    end
  endtask : stops_low

  // reset values and waiting for power-good
  task automatic t_reset;
    repeat (10) @(negedge mclk);
    check("out_before_good", clock_out_a, 9'h000);
    check("gate_bits_rst", gate_bits, COG_GATE_BIT_RST);
    check("pd_n_before_good", 9'(power_down_n), 9'h000);
    check("alive_before_good", 9'(logic_alive), 9'h001);
    check("stable_early", 9'(clocks_stable), 9'h000);
  endtask : t_reset

  // power-good qualifies, outputs start
  task automatic t_qualify;
    cog_sys_model_i.drive(1'h1, 9'h1FF);
    start_lat(0);
    check("pd_n_after_good", 9'(power_down_n), 9'h001);
    full_pulses(0);
  endtask : t_qualify

  // per-output gating by pin and by bit
  task automatic t_gate;
    cog_sys_model_i.drive(1'h1, 9'h1FE);
    stops_low(0);
    full_pulses(1);
    cog_sys_model_i.drive(1'h1, 9'h1FF);
    start_lat(0);
    wr_bits(9'h1FD);
    check("gate_bits_wr", gate_bits, 9'h1FD);
    stops_low(1);
    full_pulses(0);
    wr_bits(9'h1FF);
    start_lat(1);
  endtask : t_gate

  // power-down and restart
  task automatic t_pdown;
    cog_sys_model_i.drive(1'h0, 9'h1FF);
    stops_low(2);
    check("out_pd", clock_out_a, 9'h000);
    check("pd_n_pd", 9'(power_down_n), 9'h000);
    check("alive_pd", 9'(logic_alive), 9'h000);
    wr_bits(9'h000);
    check("write_dropped", gate_bits, 9'h1FF);
    cog_sys_model_i.drive(1'h1, 9'h1FF);
    start_lat(2);
    check("alive_back", 9'(logic_alive), 9'h001);
    full_pulses(2);
  endtask : t_pdown

  // main sequence
  initial
  begin
    n_fail          = 0;
    checks          = 0;
    rst_n           = 1'h0;
    gate_bits_we    = 1'h0;
    gate_bits_wdata = 9'h1FF;
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    t_reset();
    t_qualify();
    t_gate();
    t_pdown();
    wrap_up();
  end

  // watchdog against a hang
  initial
  begin
    #20000;
    n_fail++;
    wrap_up();
  end
endmodule : clock_output_gating_tb_top
